// ---- flash_seq_device.sv ----
/*
  Flash end of the serial link: decodes write enable/disable, status read,
  wrap setup, page/sector/half-block/block/chip erase and page program,
  and runs the self-timed cycle on a small flip-flop array.
  Assumes link pins from another clock domain; the array stands for the
  low address bits of the full memory.
*/
// Functional notes
// R1: Wrap command: opcode, 24 dummies, wrap byte.
// R2: Wrap setting persists; length 8/16/32/64 bytes.
// R3: Disable bit one means no wrap, default.
// R4: Erase and program need write enable first.
// R5: Page erase sets the addressed page to ones.
// R6: Erase needs chip select after third address byte.
// R7: Host holds chip select low whole sequence.
// R8: Valid command starts timed cycle, flag busy.
// R9: Clear write enable by cycle end.
// R10: Protected page is never page erased.
// R11: Sector erase sets sector, protection respected.
// R12: Half block erase sets half block, protected.
// R13: Block erase sets block, protection respected.
// R14: Chip erase only after exactly opcode bits.
// R15: Chip erase only with all protect bits zero.
// R16: Program carries address and data bytes.
// R17: Program address wraps within the page.
// R18: Over 256 bytes, the last 256 win.
// R19: Short program leaves other page bytes alone.
// R20: Program needs chip select at byte boundary.
// R21: Protected page is never programmed.
// R22: While busy, accept only status reads.
`timescale 1ns/10ps
module flash_seq_device #(
  parameter int unsigned MEM_BYTES = 1024,
  parameter int unsigned PAGE_ERASE_CYCLES = flash_seq_pkg::PAGE_ERASE_CYC,
  parameter int unsigned SECTOR_ERASE_CYCLES = flash_seq_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned HALF_BLOCK_ERASE_CYCLES = flash_seq_pkg::HALF_BLOCK_ERASE_CYC,
  parameter int unsigned BLOCK_ERASE_CYCLES = flash_seq_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_ERASE_CYCLES = flash_seq_pkg::CHIP_ERASE_CYC,
  parameter int unsigned PAGE_PROGRAM_CYCLES = flash_seq_pkg::PAGE_PROGRAM_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  flash_link_if.device link,
  input wire logic [4:0] block_protect_bits_i,
  input wire logic [$clog2(MEM_BYTES)-1:0] peek_addr_i,
  output logic [7:0] peek_data_o,
  output logic write_in_progress_flag_o,
  output logic write_enable_latch_o,
  output logic [2:0] wrap_setting_bits_o,
  output logic [6:0] wrap_bytes_o
);
  import flash_seq_pkg::*;

  localparam int unsigned AW = $clog2(MEM_BYTES);

  initial begin
    if (MEM_BYTES < 256 || (1 << AW) != MEM_BYTES) begin
      $error("MEM_BYTES must be a power of two of at least 256");
    end
    if (PAGE_ERASE_CYCLES < 2 || SECTOR_ERASE_CYCLES < 2 || HALF_BLOCK_ERASE_CYCLES < 2 ||
        BLOCK_ERASE_CYCLES < 2 || CHIP_ERASE_CYCLES < 2 || PAGE_PROGRAM_CYCLES < 2) begin
      $error("self-timed cycle counts must be at least two");
    end
  end

  typedef struct packed {
    logic cs_s1, cs_s2, cs_d;
    logic ck_s1, ck_s2, ck_d;
    logic si_s1, si_s2;
    logic [7:0] shift;
    logic [2:0] bitpos;
    logic [2:0] nbytes;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] pg_ptr;
    logic [255:0][7:0] pg_buf;
    logic [255:0] pg_mask;
    logic [7:0] rd_sr;
    logic so;
    logic wen;
    logic bsy;
    logic [31:0] timer;
    logic [2:0] wrap;
    logic [6:0] wrap_bytes;
    logic [MEM_BYTES-1:0][7:0] mem;
    logic [7:0] peek;
  } dev_s;

  dev_s st_r, st_nxt;

  // True when array byte idx falls in the 2^size_log2 region holding target.
  function automatic logic erase_hit(input logic [AW-1:0] idx, input logic [AW-1:0] target,
                                     input int unsigned size_log2);
    logic [AW-1:0] keep;
    keep = '1;
    for (int b = 0; b < AW; b++) begin
      if (b < size_log2) begin
        keep[b] = 1'b0;
      end
    end
    return ((idx ^ target) & keep) == '0;
  endfunction

  always_comb begin
    logic ck_rise, ck_fall, cs_fall, cs_rise, byte_done, boundary, prot, go;
    logic [7:0] byte_in;
    int unsigned size_log2;
    int unsigned dur;
    ck_rise = 1'b0;
    ck_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    byte_done = 1'b0;
    boundary = 1'b0;
    prot = 1'b0;
    go = 1'b0;
    byte_in = 8'h00;
    size_log2 = 0;
    dur = 0;
    st_nxt = st_r;

    // The second stage of each synchroniser is examined, with its delayed copy for chip select and serial clock edges.
    st_nxt.cs_s1 = link.cs_n;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.cs_d = st_r.cs_s2;
    st_nxt.ck_s1 = link.sclk;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_d = st_r.ck_s2;
    st_nxt.si_s1 = link.si;
    st_nxt.si_s2 = st_r.si_s1;
    ck_rise = st_r.ck_s2 && !st_r.ck_d && !st_r.cs_s2;
    ck_fall = !st_r.ck_s2 && st_r.ck_d && !st_r.cs_s2;
    cs_fall = !st_r.cs_s2 && st_r.cs_d;
    cs_rise = st_r.cs_s2 && !st_r.cs_d;

    if (cs_fall) begin
      st_nxt.bitpos = 3'h0;
      st_nxt.nbytes = 3'h0;
      st_nxt.op = 8'h00;
      st_nxt.pg_mask = '0;
    end

    if (ck_rise) begin
      byte_in = {st_r.shift[6:0], st_r.si_s2};
      st_nxt.shift = byte_in;
      st_nxt.bitpos = st_r.bitpos + 3'h1;
      byte_done = (st_r.bitpos == 3'h7);
    end

    if (byte_done) begin
      if (st_r.nbytes != 3'h7) begin
        st_nxt.nbytes = st_r.nbytes + 3'h1;
      end
      case (st_r.nbytes)
        3'h0: begin
          st_nxt.op = byte_in;
          st_nxt.rd_sr = {6'h00, st_r.wen, st_r.bsy};
        end
        3'h1: st_nxt.addr[23:16] = byte_in;
        3'h2: st_nxt.addr[15:8] = byte_in;
        3'h3: begin
          st_nxt.addr[7:0] = byte_in;
          st_nxt.pg_ptr = byte_in;
        end
        default: begin
          // Pointer wraps inside the page; later bytes overwrite earlier ones. [R17] [R18]
          if (st_r.op == OP_PAGE_PROGRAM) begin
            st_nxt.pg_buf[st_r.pg_ptr] = byte_in;
            st_nxt.pg_mask[st_r.pg_ptr] = 1'b1;
            st_nxt.pg_ptr = st_r.pg_ptr + 8'h01;
          end
        end
      endcase
      if (st_r.nbytes != 3'h0 && st_r.op == OP_READ_STATUS) begin
        st_nxt.rd_sr = {6'h00, st_r.wen, st_r.bsy};
      end
    end

    // Status stays readable during the timed cycle. [R8]
    if (ck_fall && st_r.op == OP_READ_STATUS && st_r.nbytes != 3'h0) begin
      st_nxt.so = st_r.rd_sr[7];
      st_nxt.rd_sr = {st_r.rd_sr[6:0], 1'b0};
    end

    boundary = (st_r.bitpos == 3'h0);
    prot = is_protected(st_r.addr, block_protect_bits_i);
    // Nothing but status reads is taken while busy. [R22]
    if (cs_rise && !st_r.bsy && boundary) begin
      case (st_r.op)
        OP_WRITE_ENABLE: begin
          if (st_r.nbytes == BYTES_OPCODE_ONLY) begin
            st_nxt.wen = 1'b1;
          end
        end
        OP_WRITE_DISABLE: begin
          if (st_r.nbytes == BYTES_OPCODE_ONLY) begin
            st_nxt.wen = 1'b0;
          end
        end
        OP_SET_WRAP: begin
          if (st_r.nbytes == BYTES_WRAP_CMD) begin // [R1]
            st_nxt.wrap = st_r.shift[WRAP_LEN_POS+1:WRAP_DISABLE_POS];
            // Disable bit set means linear reads, reported as zero length. [R2] [R3]
            st_nxt.wrap_bytes = st_r.shift[WRAP_DISABLE_POS] ? 7'h00 :
                                WRAP_BASE_BYTES << st_r.shift[WRAP_LEN_POS+1:WRAP_LEN_POS];
          end
        end
        OP_PAGE_ERASE, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE: begin
          // Exact third-address-byte boundary, latch set, region unprotected. [R4] [R6]
          go = st_r.wen && st_r.nbytes == BYTES_WITH_ADDR && !prot; // [R10] [R11] [R12] [R13]
          case (st_r.op)
            OP_PAGE_ERASE: begin
              size_log2 = PAGE_LOG2;
              dur = PAGE_ERASE_CYCLES;
            end
            OP_SECTOR_ERASE: begin
              size_log2 = SECTOR_LOG2;
              dur = SECTOR_ERASE_CYCLES;
            end
            OP_HALF_BLOCK_ERASE: begin
              size_log2 = HALF_BLOCK_LOG2;
              dur = HALF_BLOCK_ERASE_CYCLES;
            end
            default: begin
              size_log2 = BLOCK_LOG2;
              dur = BLOCK_ERASE_CYCLES;
            end
          endcase
          if (go) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
              if (erase_hit(AW'(i), st_r.addr[AW-1:0], size_log2)) begin
                st_nxt.mem[i] = 8'hff; // [R5]
              end
            end
          end
        end
        OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
          go = st_r.wen && st_r.nbytes == BYTES_OPCODE_ONLY; // [R4] [R14]
          go = go && block_protect_bits_i == 5'h00; // [R15]
          dur = CHIP_ERASE_CYCLES;
          if (go) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
              st_nxt.mem[i] = 8'hff;
            end
          end
        end
        OP_PAGE_PROGRAM: begin
          // At least one whole data byte and a byte boundary. [R4] [R20] [R21]
          go = st_r.wen && st_r.nbytes > BYTES_WITH_ADDR && !prot;
          dur = PAGE_PROGRAM_CYCLES;
          if (go) begin
            for (int i = 0; i < 256; i++) begin
              // Only bytes that were sent are touched. [R19]
              if (st_r.pg_mask[i]) begin
                st_nxt.mem[{st_r.addr[AW-1:8], 8'(i)}] =
                  st_r.mem[{st_r.addr[AW-1:8], 8'(i)}] & st_r.pg_buf[i];
              end
            end
          end
        end
        default: go = 1'b0;
      endcase
      if (go) begin
        st_nxt.bsy = 1'b1; // [R8]
        st_nxt.timer = 32'(dur);
      end
    end

    if (st_r.bsy) begin
      st_nxt.timer = st_r.timer - 32'h1;
      if (st_r.timer == 32'h1) begin
        st_nxt.bsy = 1'b0; // [R8]
        st_nxt.wen = 1'b0; // [R9]
      end
    end

    st_nxt.peek = st_r.mem[peek_addr_i];

    if (srst_i) begin
      st_nxt = '0;
      st_nxt.cs_s1 = 1'b1;
      st_nxt.cs_s2 = 1'b1;
      st_nxt.cs_d = 1'b1;
      st_nxt.wrap = WRAP_RESET; // [R3]
      for (int i = 0; i < MEM_BYTES; i++) begin
        st_nxt.mem[i] = 8'hff;
      end
      st_nxt.peek = 8'hff;
    end
  end

  always_ff @(posedge clock_i) begin
    st_r <= st_nxt;
  end

  assign link.so = st_r.so;
  assign peek_data_o = st_r.peek;
  assign write_in_progress_flag_o = st_r.bsy;
  assign write_enable_latch_o = st_r.wen;
  assign wrap_setting_bits_o = st_r.wrap;
  assign wrap_bytes_o = st_r.wrap_bytes;
endmodule

// ---- flash_seq_pkg.sv ----
/*
  Shared constants of the serial flash command sequencer: opcodes, field
  positions, self-timed cycle durations and link timing.
  Assumes a 40 MHz system clock on both ends of the serial link.
*/
package flash_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned LINK_PERIOD_NS = 200;
  localparam int unsigned LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;

  // Completed byte counts at which chip select may rise.
  localparam logic [2:0] BYTES_OPCODE_ONLY = 3'h1;
  localparam logic [2:0] BYTES_WITH_ADDR = 3'h4;
  localparam logic [2:0] BYTES_WRAP_CMD = 3'h5;

  // Erase granularity as log2 of the byte count.
  localparam int unsigned PAGE_LOG2 = 8;
  localparam int unsigned SECTOR_LOG2 = 12;
  localparam int unsigned HALF_BLOCK_LOG2 = 15;
  localparam int unsigned BLOCK_LOG2 = 16;

  // Status byte layout.
  localparam int unsigned STATUS_BSY_BIT = 0;
  localparam int unsigned STATUS_WEN_BIT = 1;

  // Wrap byte layout and reset value (wrap disabled).
  localparam int unsigned WRAP_DISABLE_POS = 4;
  localparam int unsigned WRAP_LEN_POS = 5;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam logic [6:0] WRAP_BASE_BYTES = 7'h08;

  // Self-timed cycle durations in microseconds, and cycle counts.
  localparam int unsigned PAGE_ERASE_US = 1000;
  localparam int unsigned SECTOR_ERASE_US = 2000;
  localparam int unsigned HALF_BLOCK_ERASE_US = 3000;
  localparam int unsigned BLOCK_ERASE_US = 4000;
  localparam int unsigned CHIP_ERASE_US = 8000;
  localparam int unsigned PAGE_PROGRAM_US = 500;
  localparam int unsigned PAGE_ERASE_CYC = PAGE_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned HALF_BLOCK_ERASE_CYC = HALF_BLOCK_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CHIP_ERASE_CYC = CHIP_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PAGE_PROGRAM_CYC = PAGE_PROGRAM_US * 1000 / CLK_PERIOD_NS;

  // Protection: zero protects nothing, bits 4:3 protect all, else top
  // 64 KiB blocks counted as 1 << (bits 2:0 - 1).
  function automatic logic is_protected(input logic [23:0] addr, input logic [4:0] bp);
    logic [8:0] first;
    first = 9'h100 - (9'h001 << (bp[2:0] - 3'h1));
    if (bp == 5'h00) begin
      return 1'b0;
    end
    if (bp[4] || bp[3]) begin
      return 1'b1;
    end
    return {1'b0, addr[23:16]} >= first;
  endfunction

endpackage

// ---- flash_link_if.sv ----
/*
  Serial link between the flash command sequencer and its host controller.
  Assumes the host makes chip select, serial clock and serial input, and
  the flash drives the serial output continuously.
*/
`timescale 1ns/10ps
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;

  modport device (input cs_n, input sclk, input si, output so);
  modport host (output cs_n, output sclk, output si, input so);
endinterface

// ---- flash_seq_host.sv ----
/*
  Host end of the serial link: sends one command built from an opcode,
  an optional three-byte address, a number of data bytes and optional
  stray bits, then optionally reads one status byte.
  Assumes the flash samples on rising serial clock and drives on falling.
*/
`timescale 1ns/10ps
module flash_seq_host #(
  parameter int unsigned HALF_CYCLES = flash_seq_pkg::LINK_HALF_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  flash_link_if.host link,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic cmd_addr_en_i,
  input wire logic [9:0] cmd_ndata_i,
  input wire logic [2:0] cmd_tail_bits_i,
  input wire logic cmd_read_i,
  input wire logic [7:0] data_i,
  output logic cmd_ready_o,
  output logic data_take_o,
  output logic [7:0] read_data_o,
  output logic read_valid_o
);
  import flash_seq_pkg::*;

  initial begin
    if (HALF_CYCLES < 4 || HALF_CYCLES > 255) begin
      $error("HALF_CYCLES must lie in 4..255 for the status read to meet timing");
    end
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_LOW = 4'h2,
    H_HIGH = 4'h4,
    H_STOP = 4'h8
  } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [7:0] cnt;
    logic cs_n, sclk, si;
    logic [7:0] shift;
    logic [2:0] bitpos;
    logic [10:0] byte_idx, nbytes;
    logic [13:0] out_left;
    logic [3:0] rd_left;
    logic addr_en;
    logic [23:0] addr;
    logic ready, take, rvalid;
    logic [7:0] rdata;
    logic so_s1, so_s2;
  } host_s;

  host_s h_r, h_nxt;

  always_comb begin
    logic phase_end;
    h_nxt = h_r;
    h_nxt.so_s1 = link.so;
    h_nxt.so_s2 = h_r.so_s1;
    h_nxt.take = 1'b0;
    h_nxt.rvalid = 1'b0;
    phase_end = (h_r.cnt == 8'(HALF_CYCLES - 1));
    case (h_r.st)
      H_IDLE: begin
        h_nxt.ready = 1'b1;
        if (cmd_valid_i && h_r.ready) begin
          h_nxt.ready = 1'b0;
          h_nxt.addr = cmd_addr_i;
          h_nxt.addr_en = cmd_addr_en_i;
          h_nxt.nbytes = 11'h001 + (cmd_addr_en_i ? 11'h003 : 11'h000) + {1'b0, cmd_ndata_i};
          h_nxt.out_left = {h_nxt.nbytes, 3'h0} + {11'h000, cmd_tail_bits_i};
          h_nxt.rd_left = cmd_read_i ? 4'h8 : 4'h0;
          h_nxt.shift = cmd_op_i;
          h_nxt.byte_idx = 11'h001;
          h_nxt.bitpos = 3'h0;
          h_nxt.cnt = 8'h00;
          h_nxt.cs_n = 1'b0; // [R7]
          h_nxt.st = H_LOW;
        end
      end
      H_LOW: begin
        h_nxt.cnt = h_r.cnt + 8'h01;
        h_nxt.si = (h_r.out_left != 14'h0) ? h_r.shift[7] : 1'b0;
        if (h_r.out_left == 14'h0 && h_r.rd_left == 4'h0) begin
          // Chip select rises only after the last clocked bit. [R6] [R14] [R20]
          h_nxt.cs_n = 1'b1;
          h_nxt.cnt = 8'h00;
          h_nxt.st = H_STOP;
        end else if (phase_end) begin
          h_nxt.cnt = 8'h00;
          h_nxt.sclk = 1'b1;
          h_nxt.st = H_HIGH;
        end
      end
      H_HIGH: begin
        h_nxt.cnt = h_r.cnt + 8'h01;
        if (phase_end) begin
          h_nxt.cnt = 8'h00;
          h_nxt.sclk = 1'b0;
          h_nxt.st = H_LOW;
          if (h_r.out_left != 14'h0) begin
            h_nxt.out_left = h_r.out_left - 14'h1;
            h_nxt.shift = {h_r.shift[6:0], 1'b0};
            h_nxt.bitpos = h_r.bitpos + 3'h1;
            if (h_r.bitpos == 3'h7 && h_r.byte_idx < h_r.nbytes) begin
              h_nxt.byte_idx = h_r.byte_idx + 11'h001;
              if (h_r.addr_en && h_r.byte_idx == 11'h001) begin
                h_nxt.shift = h_r.addr[23:16];
              end else if (h_r.addr_en && h_r.byte_idx == 11'h002) begin
                h_nxt.shift = h_r.addr[15:8];
              end else if (h_r.addr_en && h_r.byte_idx == 11'h003) begin
                h_nxt.shift = h_r.addr[7:0];
              end else begin
                // Data bytes follow the address. [R1] [R16]
                h_nxt.shift = data_i;
                h_nxt.take = 1'b1;
              end
            end
          end else begin
            h_nxt.rdata = {h_r.rdata[6:0], h_r.so_s2};
            h_nxt.rd_left = h_r.rd_left - 4'h1;
            h_nxt.rvalid = (h_r.rd_left == 4'h1);
          end
        end
      end
      H_STOP: begin
        h_nxt.cnt = h_r.cnt + 8'h01;
        if (phase_end) begin
          h_nxt.cnt = 8'h00;
          h_nxt.ready = 1'b1;
          h_nxt.st = H_IDLE;
        end
      end
      default: h_nxt.st = H_IDLE;
    endcase
    if (srst_i) begin
      h_nxt = '0;
      h_nxt.st = H_IDLE;
      h_nxt.cs_n = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    h_r <= h_nxt;
  end

  assign link.cs_n = h_r.cs_n;
  assign link.sclk = h_r.sclk;
  assign link.si = h_r.si;
  assign cmd_ready_o = h_r.ready;
  assign data_take_o = h_r.take;
  assign read_data_o = h_r.rdata;
  assign read_valid_o = h_r.rvalid;
endmodule

// ---- flash_seq_checker.sv ----
/*
  Checker of the serial link between the flash sequencer and its host.
  Assumes four system clocks per serial clock phase and sees only the link.
*/
`timescale 1ns/10ps
module flash_seq_checker (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence high_phase;
    (sclk && !cs_n)[*4];
  endsequence

  sequence low_phase;
    !sclk[*4];
  endsequence

  AST_RESET_IDLE: assert property ($fell(srst_i) |-> cs_n && !sclk)
    else $error("link not idle after reset");
  AST_IDLE_CLOCK_LOW: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  AST_HIGH_PHASE: assert property ($rose(sclk) |-> high_phase ##1 !sclk)
    else $error("serial clock high phase length wrong");
  AST_LOW_PHASE: assert property ($fell(sclk) |-> low_phase)
    else $error("serial clock low phase too short");
  AST_FRAME_START: assert property ($fell(cs_n) |-> low_phase)
    else $error("first bit lacks setup time");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*5])
    else $error("chip select high gap too short");
  AST_SI_STABLE: assert property (sclk && $past(sclk) |-> $stable(si))
    else $error("serial input moved while clock high");
  AST_SO_STABLE: assert property (sclk && $past(sclk) && !cs_n |-> $stable(so))
    else $error("serial output moved while clock high");
endmodule

// ---- flash_erase_program_wrap_seq_test.sv ----
/*
  Self-checking bench: host and flash ends joined by the link interface.
  Assumes default link timing and shortened self-timed cycle counts.
*/
`timescale 1ns/10ps
module flash_erase_program_wrap_seq_test;
  import flash_seq_pkg::*;
  localparam int PGE_C = 1200;
  localparam int SEC_C = 200;
  localparam int HB_C = 250;
  localparam int BLK_C = 300;
  localparam int CE_C = 350;
  localparam int PRG_C = 300;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_op_i = 8'h00;
  logic [23:0] cmd_addr_i = 24'h000000;
  logic cmd_addr_en_i = 1'b0;
  logic [9:0] cmd_ndata_i = 10'h000;
  logic [2:0] cmd_tail_bits_i = 3'h0;
  logic cmd_read_i = 1'b0;
  logic [7:0] data_i = 8'h00;
  logic [4:0] bp = 5'h00;
  logic [9:0] peek_addr_i = 10'h000;
  logic [7:0] peek_data_o, read_data_o;
  logic bsy, wen, cmd_ready_o, data_take_o, read_valid_o;
  logic [2:0] wrap_bits;
  logic [6:0] wrap_bytes;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int run = 0;
  int last_len = 0;
  logic [7:0] er_op [5] = '{OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE,
                            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  int er_cyc [5] = '{SEC_C, HB_C, BLK_C, CE_C, CE_C};
`define CHK(g, e) chk(32'(g), 32'(e))

  flash_link_if lnk ();
  flash_seq_device #(.PAGE_ERASE_CYCLES(PGE_C), .SECTOR_ERASE_CYCLES(SEC_C),
    .HALF_BLOCK_ERASE_CYCLES(HB_C), .BLOCK_ERASE_CYCLES(BLK_C), .CHIP_ERASE_CYCLES(CE_C),
    .PAGE_PROGRAM_CYCLES(PRG_C)) u_flash_seq_device (.clock_i(clock_i), .srst_i(srst_i),
    .link(lnk), .block_protect_bits_i(bp), .peek_addr_i(peek_addr_i),
    .peek_data_o(peek_data_o), .write_in_progress_flag_o(bsy), .write_enable_latch_o(wen),
    .wrap_setting_bits_o(wrap_bits), .wrap_bytes_o(wrap_bytes));
  flash_seq_host u_flash_seq_host (.clock_i(clock_i), .srst_i(srst_i), .link(lnk),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_addr_en_i(cmd_addr_en_i), .cmd_ndata_i(cmd_ndata_i),
    .cmd_tail_bits_i(cmd_tail_bits_i), .cmd_read_i(cmd_read_i), .data_i(data_i),
    .cmd_ready_o(cmd_ready_o), .data_take_o(data_take_o), .read_data_o(read_data_o),
    .read_valid_o(read_valid_o));
  flash_seq_checker u_flash_seq_checker (.clock_i(clock_i), .srst_i(srst_i),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .si(lnk.si), .so(lnk.so));

  always #12.5 clock_i = ~clock_i;

  // The busy length is measured here so that it is exact however late a test looks.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (bsy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    if (cyc > 80000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Data byte k is d0 + k plus a mark per 256 bytes, so overlong bursts stay visible.
  task cmd(input logic [7:0] op, input logic [23:0] a, input logic ae, input int n,
           input logic [2:0] tb, input logic rd, input logic [7:0] d0);
    int k;
    int w;
    k = 0;
    w = 0;
    while (cmd_ready_o !== 1'b1 && w < 3000) begin
      @(posedge clock_i);
      w++;
    end
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_addr_en_i <= ae;
    cmd_ndata_i <= 10'(n);
    cmd_tail_bits_i <= tb;
    cmd_read_i <= rd;
    data_i <= d0;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    do begin
      @(posedge clock_i);
      if (data_take_o === 1'b1) begin
        k++;
        data_i <= d0 + 8'(k) + {2'(k >> 8), 6'h00};
      end
    end while (cmd_ready_o !== 1'b1);
  endtask

  task pk(input logic [9:0] a, input logic [7:0] e);
    peek_addr_i <= a;
    repeat (2) @(posedge clock_i);
    `CHK(peek_data_o, e);
  endtask

  task busy(input int e);
    int w;
    w = 0;
    repeat (2) @(posedge clock_i);
    while (bsy === 1'b1 && w < 20000) begin
      @(posedge clock_i);
      w++;
    end
    @(posedge clock_i);
    `CHK(last_len, e);
  endtask

  task t_reset;
    `CHK(bsy, 1'b0);
    `CHK(wen, 1'b0);
    `CHK(wrap_bits, 3'h1);
    `CHK(wrap_bytes, 7'h00);
    pk(10'h000, 8'hff);
    $display("reset test done");
  endtask

  task t_wrap;
    for (int i = 0; i < 4; i++) begin
      cmd(OP_SET_WRAP, 24'h0, 1'b1, 1, 3'h0, 1'b0, {1'b0, 2'(i), 1'b0, 4'h0});
      `CHK(wrap_bits, {2'(i), 1'b0});
      `CHK(wrap_bytes, 7'h08 << i);
    end
    cmd(OP_SET_WRAP, 24'h0, 1'b1, 1, 3'h3, 1'b0, 8'h10);
    `CHK(wrap_bits, 3'h6);
    cmd(OP_SET_WRAP, 24'h0, 1'b1, 1, 3'h0, 1'b0, 8'h70);
    `CHK(wrap_bits, 3'h7);
    `CHK(wrap_bytes, 7'h00);
    $display("wrap test done");
  endtask

  task t_program;
    cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    `CHK(wen, 1'b1);
    cmd(OP_PAGE_PROGRAM, 24'h000010, 1'b1, 2, 3'h0, 1'b0, 8'ha5);
    busy(PRG_C);
    `CHK(wen, 1'b0);
    pk(10'h010, 8'ha5);
    pk(10'h011, 8'ha6);
    pk(10'h012, 8'hff);
    $display("program test done");
  endtask

  task t_refuse;
    cmd(OP_PAGE_PROGRAM, 24'h000020, 1'b1, 1, 3'h0, 1'b0, 8'h00);
    `CHK(bsy, 1'b0);
    pk(10'h020, 8'hff);
    cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    cmd(OP_PAGE_PROGRAM, 24'h000020, 1'b1, 1, 3'h3, 1'b0, 8'h00);
    pk(10'h020, 8'hff);
    cmd(OP_PAGE_ERASE, 24'h000010, 1'b1, 0, 3'h3, 1'b0, 8'h00);
    pk(10'h010, 8'ha5);
    cmd(OP_CHIP_ERASE_A, 24'h0, 1'b0, 1, 3'h0, 1'b0, 8'h00);
    pk(10'h010, 8'ha5);
    `CHK(wen, 1'b1);
    cmd(OP_WRITE_DISABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    `CHK(wen, 1'b0);
    cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    $display("refuse test done");
  endtask

  task t_protect;
    bp <= 5'h08;
    cmd(OP_PAGE_ERASE, 24'h000010, 1'b1, 0, 3'h0, 1'b0, 8'h00);
    pk(10'h010, 8'ha5);
    cmd(OP_PAGE_PROGRAM, 24'h000010, 1'b1, 1, 3'h0, 1'b0, 8'h00);
    pk(10'h010, 8'ha5);
    cmd(OP_CHIP_ERASE_B, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    pk(10'h010, 8'ha5);
    `CHK(bsy, 1'b0);
    bp <= 5'h00;
    $display("protect test done");
  endtask

  task t_wrap_prog;
    cmd(OP_PAGE_PROGRAM, 24'h0001fe, 1'b1, 4, 3'h0, 1'b0, 8'h30);
    busy(PRG_C);
    pk(10'h1ff, 8'h31);
    pk(10'h100, 8'h32);
    pk(10'h101, 8'h33);
    pk(10'h102, 8'hff);
    cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    cmd(OP_PAGE_PROGRAM, 24'h000200, 1'b1, 258, 3'h0, 1'b0, 8'h00);
    busy(PRG_C);
    pk(10'h200, 8'h40);
    pk(10'h201, 8'h41);
    pk(10'h202, 8'h02);
    $display("page wrap test done");
  endtask

  task t_erase_busy;
    cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
    cmd(OP_PAGE_ERASE, 24'h0002a5, 1'b1, 0, 3'h0, 1'b0, 8'h00);
    cmd(OP_SET_WRAP, 24'h0, 1'b1, 1, 3'h0, 1'b0, 8'h00);
    `CHK(wrap_bits, 3'h7);
    cmd(OP_READ_STATUS, 24'h0, 1'b0, 0, 3'h0, 1'b1, 8'h00);
    `CHK(read_data_o, 8'h03);
    busy(PGE_C);
    `CHK(wen, 1'b0);
    pk(10'h200, 8'hff);
    pk(10'h2ff, 8'hff);
    pk(10'h1ff, 8'h31);
    $display("page erase test done");
  endtask

  task t_erases;
    for (int i = 0; i < 5; i++) begin
      cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
      cmd(OP_PAGE_PROGRAM, 24'h000105, 1'b1, 1, 3'h0, 1'b0, 8'h00);
      busy(PRG_C);
      cmd(OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 3'h0, 1'b0, 8'h00);
      bp <= 5'h01;
      cmd(er_op[i], 24'hff0000, 1'(i < 3), 0, 3'h0, 1'b0, 8'h00);
      pk(10'h105, 8'h00);
      bp <= 5'h00;
      cmd(er_op[i], 24'h000105, 1'(i < 3), 0, 3'h0, 1'b0, 8'h00);
      busy(er_cyc[i]);
      pk(10'h105, 8'hff);
      `CHK(wen, 1'b0);
    end
    $display("erase test done");
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    t_reset();
    t_wrap();
    t_program();
    t_refuse();
    t_protect();
    t_wrap_prog();
    t_erase_busy();
    t_erases();
    give_verdict();
  end
endmodule
